/* verilog/sfi_pkg.sv */
package sfi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_MHZ      = 40;        // system clock rate
  localparam int unsigned POWERUP_NS   = 300000;    // powerup_interval
  localparam int unsigned RST_PULSE_NS = 200;       // reset_pulse_time, least
  localparam int unsigned RST_PROC_NS  = 35000;     // reset_process_time, least
  localparam int unsigned RST_HOLD_NS  = 50;        // reset_release_hold, least
  // least times round up to whole cycles
  localparam int unsigned POR_CYC_DEF  = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RP_CYC_DEF   = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RPH_CYC_DEF  = (RST_PROC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RH_CYC_DEF   = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W        = 24;        // timer width

  ////////////////////////////////////////////////////////////////////////////
  // lane widths and latency codes
  localparam logic [1:0] W_SINGLE = 2'h0;           // one lane
  localparam logic [1:0] W_DUAL   = 2'h1;           // lanes 0..1
  localparam logic [1:0] W_QUAD   = 2'h2;           // lanes 0..3
  localparam logic [5:0] LAT_CODE0 = 6'h08;         // latency cycles per code
  localparam logic [5:0] LAT_CODE1 = 6'h04;
  localparam logic [5:0] LAT_CODE2 = 6'h05;
  localparam logic [5:0] LAT_CODE3 = 6'h06;
  localparam logic [3:0] BYTE_BITS = 4'h8;          // bits per byte

  ////////////////////////////////////////////////////////////////////////////
  // interface states, one-hot
  typedef enum logic [8:0] {
    ST_POR   = 9'h001,                              // power-up interval
    ST_WRST  = 9'h002,                              // warm reset process
    ST_STBY  = 9'h004,                              // interface standby
    ST_INSTR = 9'h008,                              // instruction bits
    ST_DEC   = 9'h010,                              // format fetch
    ST_ADDR  = 9'h020,                              // address / mode input
    ST_LAT   = 9'h040,                              // latency cycles
    ST_DIN   = 9'h080,                              // data input
    ST_DOUT  = 9'h100                               // data output
  } sfi_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       reset_n;                            // hardware reset, low active
    logic       cs_n;                               // chip select, low active
    logic       sck;                                // host serial clock
    logic [3:0] lane;                               // lane3..lane0 input levels
    logic       supply_low;                         // core below cut-off
  } sfi_pin_t;

  typedef struct packed {
    logic       ddr;                                // both-edge transfers
    logic [1:0] addr_w;                             // address lane width
    logic [5:0] addr_cyc;                           // address captures, 0 none
    logic [1:0] din_w;                              // data input width
    logic       out_en;                             // command returns data
    logic [1:0] out_w;                              // output lane width
  } sfi_fmt_t;

  typedef struct packed {
    logic       first;                              // first byte after instruction
    logic [7:0] data;                               // received byte
  } sfi_rx_t;

  // number of lanes for a width code
  function automatic logic [3:0] wbits(input logic [1:0] wc);
    case (wc)
      W_DUAL:  wbits = 4'h2;
      W_QUAD:  wbits = 4'h4;
      default: wbits = 4'h1;
    endcase
  endfunction

  // shift lanes into a byte, lane0 is the least significant
  function automatic logic [7:0] cap(input logic [7:0] sr, input logic [3:0] ln, input logic [1:0] wc);
    case (wc)
      W_DUAL:  cap = {sr[5:0], ln[1:0]};
      W_QUAD:  cap = {sr[3:0], ln};
      default: cap = {sr[6:0], ln[0]};
    endcase
  endfunction

endpackage

/* verilog/sfi_fifo.sv */
`timescale 1ns/1ps

// small circular buffer with valid/ready on both sides
module sfi_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;               // entries
    logic [AW-1:0]               wp;                // write index
    logic [AW-1:0]               rp;                // read index
    logic [AW:0]                 cnt;               // fill level
  } sfi_fifo_st_t;

  sfi_fifo_st_t s_r;
  sfi_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////////////
  // handshakes and next state
  always_comb
  begin
    in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    out_valid = (s_r.cnt != '0);
    out_data  = s_r.mem[s_r.rp];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    s_nxt     = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + AW'(1);
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + AW'(1);
    end
    // level moves only when exactly one side acts
    if (push && !pop)
    begin
      s_nxt.cnt = s_r.cnt + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule // sfi_fifo

/* verilog/sfi_iface.sv */
`timescale 1ns/1ps

// Overview of operation
// - standby ignores all but reset and select fall, lanes float
// - chip select fall starts instruction cycle
// - power-up interval ignores inputs, drives nothing
// - warm reset needs pulse, process, release hold
// - low supply blocks any new command
// - single latency: no drive, input ignored
// - dual latency: no lane driven
// - quad latency: no lane driven
// - quad page program address on lane0 only
// - DDR latency: device leaves lanes floating
// - DDR single output on lane1 only
// - DDR quad output drives all until deselect
// - eight instruction bits, msb first, rising edges
// - lane3 low pauses when quad disabled
// - latency count from two-bit latency code
// - DDR commands ignore pause function
module sfi_iface #(
  parameter int unsigned POR_CYC = sfi_pkg::POR_CYC_DEF,
  parameter int unsigned RP_CYC  = sfi_pkg::RP_CYC_DEF,
  parameter int unsigned RPH_CYC = sfi_pkg::RPH_CYC_DEF,
  parameter int unsigned RH_CYC  = sfi_pkg::RH_CYC_DEF
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire sfi_pkg::sfi_pin_t pins_in,
  output logic [3:0]            lane_out,
  output logic [3:0]            lane_oe,
  input  wire logic             quad_enable,
  input  wire logic [1:0]       latency_code,
  output logic [7:0]            instr_byte,
  output logic                  instr_valid,
  input  wire sfi_pkg::sfi_fmt_t fmt_in,
  output sfi_pkg::sfi_rx_t      rx_data,
  output logic                  rx_valid,
  input  wire logic             rx_ready,
  output logic                  overrun,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_take,
  output sfi_pkg::sfi_state_t   if_state
);

  typedef struct packed {
    sfi_pkg::sfi_state_t       st;                  // interface state
    sfi_pkg::sfi_pin_t         meta;                // first sync stage
    sfi_pkg::sfi_pin_t         sync;                // second sync stage
    logic                      sck_prev;            // for edge detect
    logic                      cs_prev;             // for select edge
    logic [7:0]                in_sr;               // input shifter
    logic [3:0]                bit_cnt;             // bits in shifter
    logic                      first;               // next byte is first
    logic [5:0]                cyc;                 // phase edge count
    sfi_pkg::sfi_fmt_t         fmt;                 // current format
    logic [7:0]                out_sr;              // output shifter
    logic [3:0]                out_left;            // bits left in shifter
    logic [3:0]                lo;                  // lane levels
    logic [3:0]                oe;                  // lane enables
    logic [7:0]                instr;               // last instruction
    logic                      iv;                  // instruction pulse
    logic                      ovr;                 // byte dropped
    logic [sfi_pkg::CNT_W-1:0] por_cnt;             // power-up timer
    logic [sfi_pkg::CNT_W-1:0] lo_cnt;              // reset low timer
    logic [sfi_pkg::CNT_W-1:0] proc_cnt;            // reset process timer
    logic [sfi_pkg::CNT_W-1:0] hold_cnt;            // release hold timer
  } sfi_st_t;

  sfi_st_t          s_r;
  sfi_st_t          s_nxt;
  logic             rise;                           // qualified sck rise
  logic             fall;                           // qualified sck fall
  logic             in_cmd;                         // command in flight
  logic             hold_act;                       // pause in force
  logic             do_cap;                         // capture this cycle
  logic [1:0]       cap_w;                          // capture width
  logic             do_shift;                       // drive next bits
  logic             push;                           // byte complete
  logic [3:0]       nbits;                          // bits after capture
  logic [5:0]       lat;                            // latency cycles
  logic [8:0]       fifo_in;                        // buffer input word
  logic             fifo_rdy;                       // buffer has room
  logic [8:0]       fifo_out;                       // buffer output word

  localparam logic [sfi_pkg::CNT_W-1:0] CNT_ONE = sfi_pkg::CNT_W'(1);

  // latency code lookup
  function automatic logic [5:0] lat_of(input logic [1:0] code);
    case (code)
      2'h1:    lat_of = sfi_pkg::LAT_CODE1;
      2'h2:    lat_of = sfi_pkg::LAT_CODE2;
      2'h3:    lat_of = sfi_pkg::LAT_CODE3;
      default: lat_of = sfi_pkg::LAT_CODE0;
    endcase
  endfunction

  // lanes owned by the device in a state
  function automatic logic [3:0] oe_of(input sfi_pkg::sfi_state_t st, input sfi_pkg::sfi_fmt_t f);
    oe_of = 4'h0;
    if (st == sfi_pkg::ST_DOUT)
    begin
      case (f.out_w)
        sfi_pkg::W_DUAL: oe_of = 4'h3;
        sfi_pkg::W_QUAD: oe_of = 4'hf;
        default:         oe_of = 4'h2;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = pins_in;
    s_nxt.sync = s_r.meta;
    s_nxt.sck_prev = s_r.sync.sck;
    s_nxt.cs_prev  = s_r.sync.cs_n;
    s_nxt.iv   = 1'b0;
    in_cmd = (s_r.st == sfi_pkg::ST_INSTR) || (s_r.st == sfi_pkg::ST_DEC) || (s_r.st == sfi_pkg::ST_ADDR)
          || (s_r.st == sfi_pkg::ST_LAT) || (s_r.st == sfi_pkg::ST_DIN) || (s_r.st == sfi_pkg::ST_DOUT);
    hold_act = in_cmd && !quad_enable && !s_r.fmt.ddr && !s_r.sync.lane[3];
    rise     = s_r.sync.sck && !s_r.sck_prev && !hold_act;
    fall     = !s_r.sync.sck && s_r.sck_prev && !hold_act;
    lat      = lat_of(latency_code);
    do_cap   = 1'b0;
    cap_w    = sfi_pkg::W_SINGLE;
    do_shift = 1'b0;
    push     = 1'b0;
    nbits    = s_r.bit_cnt;
    tx_take  = 1'b0;
    case (s_r.st)
      sfi_pkg::ST_POR:
      begin
        s_nxt.por_cnt = s_r.por_cnt + CNT_ONE;
        if (s_r.por_cnt >= sfi_pkg::CNT_W'(POR_CYC - 1))
        begin
          s_nxt.st = sfi_pkg::ST_STBY;
        end
      end
      // process time and release hold both needed
      sfi_pkg::ST_WRST:
      begin
        if (s_r.proc_cnt < sfi_pkg::CNT_W'(RPH_CYC))
        begin
          s_nxt.proc_cnt = s_r.proc_cnt + CNT_ONE;
        end
        if (!s_r.sync.reset_n)
        begin
          s_nxt.hold_cnt = '0;
        end
        else if (s_r.hold_cnt < sfi_pkg::CNT_W'(RH_CYC))
        begin
          s_nxt.hold_cnt = s_r.hold_cnt + CNT_ONE;
        end
        if (s_r.proc_cnt >= sfi_pkg::CNT_W'(RPH_CYC) && s_r.hold_cnt >= sfi_pkg::CNT_W'(RH_CYC))
        begin
          s_nxt.st = sfi_pkg::ST_STBY;
        end
      end
      // standby waits for a select fall or a reset pulse
      sfi_pkg::ST_STBY:
      begin
        s_nxt.fmt = '0;
        // low supply keeps the port idle
        if (!s_r.sync.cs_n && s_r.cs_prev && !s_r.sync.supply_low)
        begin
          s_nxt.st      = sfi_pkg::ST_INSTR;
          s_nxt.bit_cnt = 4'h0;
          s_nxt.cyc     = 6'h00;
          s_nxt.ovr     = 1'b0;
          s_nxt.first   = 1'b1;
          s_nxt.out_left = 4'h0;
        end
      end
      // eight bits on lane0, msb first
      sfi_pkg::ST_INSTR:
      begin
        if (rise)
        begin
          s_nxt.in_sr = sfi_pkg::cap(s_r.in_sr, s_r.sync.lane, sfi_pkg::W_SINGLE);
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
          if (s_r.bit_cnt == sfi_pkg::BYTE_BITS - 4'h1)
          begin
            s_nxt.instr   = s_nxt.in_sr;
            s_nxt.iv      = 1'b1;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.st      = sfi_pkg::ST_DEC;
          end
        end
      end
      // take the format the decoder gives for this instruction
      sfi_pkg::ST_DEC:
      begin
        s_nxt.fmt = fmt_in;
        s_nxt.cyc = 6'h00;
        if (fmt_in.addr_cyc != 6'h00)
        begin
          s_nxt.st = sfi_pkg::ST_ADDR;
        end
        else if (fmt_in.out_en)
        begin
          s_nxt.st = sfi_pkg::ST_LAT;
        end
        else
        begin
          s_nxt.st = sfi_pkg::ST_DIN;
        end
      end
      sfi_pkg::ST_ADDR:
      begin
        do_cap = rise || (s_r.fmt.ddr && fall);
        cap_w  = s_r.fmt.addr_w;
        if (do_cap)
        begin
          s_nxt.cyc = s_r.cyc + 6'h01;
          if (s_nxt.cyc == s_r.fmt.addr_cyc)
          begin
            s_nxt.cyc = 6'h00;
            if (!s_r.fmt.out_en)
            begin
              s_nxt.st = sfi_pkg::ST_DIN;
            end
            else if (s_r.fmt.ddr && fall && lat == 6'h00)
            begin
              s_nxt.st = sfi_pkg::ST_DOUT;
              do_shift = 1'b1;
            end
            else
            begin
              s_nxt.st = sfi_pkg::ST_LAT;
            end
          end
        end
      end
      sfi_pkg::ST_LAT:
      begin
        if (fall)
        begin
          if (s_r.cyc == lat)
          begin
            s_nxt.st = sfi_pkg::ST_DOUT;
            do_shift = 1'b1;
          end
          else
          begin
            s_nxt.cyc = s_r.cyc + 6'h01;
          end
        end
      end
      // host drives the data lanes here
      sfi_pkg::ST_DIN:
      begin
        do_cap = rise || (s_r.fmt.ddr && fall);
        cap_w  = s_r.fmt.din_w;
      end
      sfi_pkg::ST_DOUT:
      begin
        do_shift = fall || (s_r.fmt.ddr && rise);
      end
      default:
      begin
        s_nxt.st = sfi_pkg::ST_STBY;
      end
    endcase
    // capture input lanes, hand full bytes to the buffer
    if (do_cap)
    begin
      s_nxt.in_sr = sfi_pkg::cap(s_r.in_sr, s_r.sync.lane, cap_w);
      nbits = s_r.bit_cnt + sfi_pkg::wbits(cap_w);
      s_nxt.bit_cnt = nbits;
      if (nbits >= sfi_pkg::BYTE_BITS)
      begin
        push = 1'b1;
        s_nxt.bit_cnt = 4'h0;
        s_nxt.first = 1'b0;
        // no room: word is lost and flagged
        if (!fifo_rdy)
        begin
          s_nxt.ovr = 1'b1;
        end
      end
    end
    // drive the next group of output bits, msb first
    if (do_shift)
    begin
      s_nxt.out_sr = s_r.out_sr;
      s_nxt.out_left = s_r.out_left;
      if (s_r.out_left == 4'h0)
      begin
        tx_take = 1'b1;
        s_nxt.out_sr = tx_data;
        s_nxt.out_left = sfi_pkg::BYTE_BITS;
      end
      case (s_r.fmt.out_w)
        sfi_pkg::W_DUAL: s_nxt.lo = {2'h0, s_nxt.out_sr[7:6]};
        sfi_pkg::W_QUAD: s_nxt.lo = s_nxt.out_sr[7:4];
        default:         s_nxt.lo = {2'h0, s_nxt.out_sr[7], 1'b0};
      endcase
      s_nxt.out_sr   = s_nxt.out_sr << sfi_pkg::wbits(s_r.fmt.out_w);
      s_nxt.out_left = s_nxt.out_left - sfi_pkg::wbits(s_r.fmt.out_w);
    end
    if (in_cmd && s_r.sync.cs_n)
    begin
      s_nxt.st = sfi_pkg::ST_STBY;
    end
    // reset pulse must last its least time
    if (!s_r.sync.reset_n && s_r.st != sfi_pkg::ST_POR)
    begin
      if (s_r.lo_cnt < sfi_pkg::CNT_W'(RP_CYC))
      begin
        s_nxt.lo_cnt = s_r.lo_cnt + CNT_ONE;
      end
      if (s_nxt.lo_cnt >= sfi_pkg::CNT_W'(RP_CYC) && s_r.st != sfi_pkg::ST_WRST)
      begin
        s_nxt.st       = sfi_pkg::ST_WRST;
        s_nxt.proc_cnt = '0;
        s_nxt.hold_cnt = '0;
      end
    end
    else
    begin
      s_nxt.lo_cnt = '0;
    end
    // enables follow the state, off in pause
    s_nxt.oe = hold_act ? 4'h0 : oe_of(s_nxt.st, s_nxt.fmt);
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_r      <= '0;
      s_r.st   <= sfi_pkg::ST_POR;
      s_r.meta <= '1;
      s_r.sync <= '1;
      s_r.sck_prev <= 1'b1;
      s_r.cs_prev  <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // received-byte buffer
  assign fifo_in = {s_r.first, s_nxt.in_sr};

  sfi_fifo #(
    .WIDTH (9),
    .DEPTH (2)
  ) u_rx_buf (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_data   (fifo_in),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .out_data  (fifo_out),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // outputs
  assign rx_data     = sfi_pkg::sfi_rx_t'(fifo_out);
  assign lane_out    = s_r.lo;
  assign lane_oe     = s_r.oe;
  assign instr_byte  = s_r.instr;
  assign instr_valid = s_r.iv;
  assign overrun     = s_r.ovr;
  assign if_state    = s_r.st;

endmodule // sfi_iface

/* dv/sfi_iface_properties.sv */
`timescale 1ns/1ps
// lane ownership and state sequencing seen at the block's ports
module sfi_iface_chk (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire sfi_pkg::sfi_pin_t   pins_in,
  input wire logic [3:0]          lane_oe,
  input wire logic                quad_enable,
  input wire logic [7:0]          instr_byte,
  input wire logic                instr_valid,
  input wire sfi_pkg::sfi_fmt_t   fmt_in,
  input wire logic                tx_take,
  input wire sfi_pkg::sfi_state_t if_state
);
  // one domain: system clock, reset disables all
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // quiet states: no lane driven
  property p_por_quiet;
    if_state == sfi_pkg::ST_POR |-> lane_oe == 4'h0 && !instr_valid;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("drive in power-up");
  property p_stby_quiet;
    (if_state == sfi_pkg::ST_STBY) [*2] |-> lane_oe == 4'h0;
  endproperty
  a_stby_quiet: assert property (p_stby_quiet) else $error("drive in standby");
  property p_input_quiet;
    (if_state inside {sfi_pkg::ST_INSTR, sfi_pkg::ST_DEC, sfi_pkg::ST_ADDR, sfi_pkg::ST_DIN}) [*2]
      |-> lane_oe == 4'h0;
  endproperty
  a_input_quiet: assert property (p_input_quiet) else $error("drive in input phase");
  property p_lat_quiet;
    (if_state == sfi_pkg::ST_LAT) [*2] |-> lane_oe == 4'h0;
  endproperty
  a_lat_quiet: assert property (p_lat_quiet) else $error("drive in latency");
  ////////////////////////////////////////////////////////////////////////////
  // sequencing and refusals
  property p_cs_ends;
    (pins_in.cs_n) [*6] |-> if_state inside {sfi_pkg::ST_POR, sfi_pkg::ST_WRST, sfi_pkg::ST_STBY};
  endproperty
  a_cs_ends: assert property (p_cs_ends) else $error("command kept after deselect");
  property p_supply;
    (pins_in.supply_low) [*4] ##0 if_state == sfi_pkg::ST_STBY |=> if_state != sfi_pkg::ST_INSTR;
  endproperty
  a_supply: assert property (p_supply) else $error("command under low supply");
  property p_instr_pulse;
    instr_valid |=> !instr_valid && $stable(instr_byte);
  endproperty
  a_instr_pulse: assert property (p_instr_pulse) else $error("instruction pulse too long");
  property p_single_out;
    if_state == sfi_pkg::ST_DOUT && fmt_in.out_w == sfi_pkg::W_SINGLE |-> lane_oe[3:2] == 2'h0 && !lane_oe[0];
  endproperty
  a_single_out: assert property (p_single_out) else $error("single output on wrong lane");
  property p_pause;
    (!quad_enable && !fmt_in.ddr && !pins_in.lane[3]) [*4] |-> lane_oe == 4'h0;
  endproperty
  a_pause: assert property (p_pause) else $error("drive while paused");
  property p_take_out;
    tx_take |-> if_state inside {sfi_pkg::ST_LAT, sfi_pkg::ST_DOUT};
  endproperty
  a_take_out: assert property (p_take_out) else $error("byte taken outside output");
endmodule // sfi_iface_chk

bind sfi_iface sfi_iface_chk u_chk (.clk_sys, .sys_rst, .pins_in, .lane_oe, .quad_enable, .instr_byte,
  .instr_valid, .fmt_in, .tx_take, .if_state);

/* dv/sfi_host_model.sv */
`timescale 1ns/1ps
// host side: mode 0 clock, select, lane0 data; lane3 is the hold level
module sfi_host_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] lane_wire,
  output logic            sck,
  output logic            cs_n,
  output logic            lane0_in,
  output logic            hold_n
);
  // idle: deselected, clock low
  initial
  begin
    sck      = 1'h0;
    cs_n     = 1'h1;
    lane0_in = 1'h0;
    hold_n   = 1'h1;
  end
  // one link cycle, four system clocks per half (100 ns), still past the sync delay
  // lane0 only
  task automatic cyc(input logic d, output logic s);
    @(posedge clk_sys);
    sck      <= 1'h0;
    lane0_in <= d;
    repeat (3) @(posedge clk_sys);
    @(posedge clk_sys);
    sck <= 1'h1;
    s = lane_wire[1];
    repeat (3) @(posedge clk_sys);
  endtask
  // whole command: n_in host cycles, n_out cycles read from lane1, then deselect
  task automatic frame(input logic [31:0] bits, input int n_in, input int n_out, output logic [7:0] got);
    logic s;
    got = 8'h00;
    @(posedge clk_sys);
    cs_n <= 1'h0;
    for (int i = 0; i < n_in + n_out; i++)
    begin
      cyc(bits[31 - (i % 32)], s);
      if (i >= n_in)
        got = {got[6:0], s};
    end
    // pause starts with the closing fall, while still selected
    @(posedge clk_sys);
    sck <= 1'h0;
    hold_n <= 1'h0;
    repeat (5) @(posedge clk_sys);
    cs_n   <= 1'h1;
    repeat (7) @(posedge clk_sys);
    hold_n <= 1'h1;
  endtask
endmodule // sfi_host_model

/* dv/testbench.sv */
`timescale 1ns/1ps
// drives the interface through the host model, checks results in arrival order
module testbench;
  localparam int POR_T = 20;                   // shortened power-up count
  localparam int RPH_T = 10;                   // shortened reset process count
  logic                clk_sys, sys_rst, reset_n, supply_low, quad_enable, rx_ready, flip;
  logic                instr_valid, rx_valid, overrun, tx_take, sck, cs_n, lane0_in, hold_n;
  logic [1:0]          latency_code;
  logic [7:0]          tx_data, got, instr_byte;
  logic [31:0]         bits, rnd;
  logic [3:0]          lane, lane_out, lane_oe;
  logic [9:0]          seen;
  logic [9:0]          exp_q[$];               // kind, first flag, byte
  int                  lat_tab[4];
  int                  n, seed;
  int                  mismatches = 0;
  int                  n_compared = 0;
  sfi_pkg::sfi_pin_t   pins_in;
  sfi_pkg::sfi_fmt_t   fmt_in;
  sfi_pkg::sfi_rx_t    rx_data;
  sfi_pkg::sfi_state_t if_state;
  ////////////////////////////////////////////////////////////////////////////
  // wire levels: device where enabled, else host or a changing pattern
  // host keeps lanes 0 and 3 driven when the device lets go, lanes 1..2 get the changing pattern
  assign lane    = (lane_oe & lane_out) | (~lane_oe & {hold_n, flip, ~flip, lane0_in});
  assign pins_in = {reset_n, cs_n, sck, lane, supply_low};
  sfi_iface #(.POR_CYC(POR_T), .RP_CYC(2), .RPH_CYC(RPH_T), .RH_CYC(2)) dut (
    .clk_sys, .sys_rst, .pins_in, .lane_out, .lane_oe, .quad_enable, .latency_code, .instr_byte,
    .instr_valid, .fmt_in, .rx_data, .rx_valid, .rx_ready, .overrun, .tx_data, .tx_take, .if_state);
  sfi_host_model host (.clk_sys, .lane_wire(lane), .sck, .cs_n, .lane0_in, .hold_n);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) flip <= ~flip;
  ////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got_v);
    n_compared++;
    if (got_v !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got_v);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // bounded wait for standby, cycles counted
  task automatic wait_stby(output int k);
    k = 0;
    while (if_state !== sfi_pkg::ST_STBY && k < 200)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  // results take the oldest note
  always @(posedge clk_sys)
  begin
    if (instr_valid === 1'h1 || (rx_valid === 1'h1 && rx_ready === 1'h1))
    begin
      seen = (instr_valid === 1'h1) ? {2'h0, instr_byte} : {1'h1, rx_data};
      check("result", exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff, seen);
    end
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 32'h45d1;
    {clk_sys, flip, supply_low, quad_enable, latency_code, rx_ready, tx_data} = '0;
    {sys_rst, reset_n} = 2'h3;
    fmt_in = '0;
    lat_tab = '{sfi_pkg::LAT_CODE0, sfi_pkg::LAT_CODE1, sfi_pkg::LAT_CODE2, sfi_pkg::LAT_CODE3};
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(negedge clk_sys);
    check("if_state", {1'h0, sfi_pkg::ST_POR}, {1'h0, if_state});
    wait_stby(n);
    check("por_wait", 10'h001, {9'h000, n >= POR_T - 2 && n < 200});
    // write: instruction and three bytes into a stalled two-entry buffer
    bits = $random(seed);
    exp_q.push_back({2'h0, bits[31:24]});
    exp_q.push_back({2'h3, bits[23:16]});
    exp_q.push_back({2'h2, bits[15:8]});
    host.frame(bits, 32, 0, got);
    @(negedge clk_sys);
    check("overrun", 10'h001, {9'h000, overrun});
    @(posedge clk_sys);
    rx_ready <= 1'h1;
    fmt_in.addr_cyc <= 6'h08;
    fmt_in.out_en <= 1'h1;
    repeat (4) @(negedge clk_sys);
    check("rx_valid", 10'h000, {9'h000, rx_valid});
    // reads with every latency code, one byte back on lane1
    for (int c = 0; c < 4; c++)
    begin
      rnd = $random(seed);
      bits = $random(seed);
      @(posedge clk_sys);
      latency_code <= 2'(c);
      tx_data <= rnd[7:0];
      exp_q.push_back({2'h0, bits[31:24]});
      exp_q.push_back({2'h3, bits[23:16]});
      host.frame(bits, 16 + lat_tab[c], 8, got);
      check("read_byte", {2'h0, rnd[7:0]}, {2'h0, got});
    end
    // low supply: the command is ignored
    @(posedge clk_sys);
    supply_low <= 1'h1;
    repeat (4) @(posedge clk_sys);
    host.frame($random(seed), 8, 0, got);
    @(negedge clk_sys);
    check("if_state", {1'h0, sfi_pkg::ST_STBY}, {1'h0, if_state});
    @(posedge clk_sys);
    supply_low <= 1'h0;
    // warm reset: low pulse, standby only after process and release hold
    reset_n <= 1'h0;
    repeat (6) @(negedge clk_sys);
    check("if_state", {1'h0, sfi_pkg::ST_WRST}, {1'h0, if_state});
    @(posedge clk_sys);
    reset_n <= 1'h1;
    wait_stby(n);
    check("wrst_wait", 10'h001, {9'h000, n + 8 >= RPH_T + 2 && n < 200});
    tally_and_finish();
  end
endmodule // testbench
